// file: design/i2cms_buf.sv
`timescale 1ns/1ps
module i2cms_buf
  import i2cms_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = BUF_DEPTH
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0]           cnt;
    logic                    in_ready;
    logic                    out_valid;
  } i2cms_buf_st_t;

  i2cms_buf_st_t r;
  i2cms_buf_st_t q;
  logic [CW-1:0] left;

  // Head always sits in entry zero so the output is a plain flop
  always_comb begin
    q = r;
    left = r.cnt;
    if (r.out_valid && out_ready) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        q.mem[i] = r.mem[i + 1];
      end
      left = r.cnt - 1'b1;
    end
    if (in_valid && r.in_ready) begin
      q.mem[left] = in_data;
      q.cnt = left + 1'b1;
    end else begin
      q.cnt = left;
    end
    q.out_valid = (q.cnt != '0);
    q.in_ready = (q.cnt != CW'(DEPTH));
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.in_ready <= 1'h1;
    end else begin
      r <= q;
    end
  end

  assign in_ready = r.in_ready;
  assign out_valid = r.out_valid;
  assign out_data = r.mem[0];
endmodule

// file: design/i2cms_if.sv
`timescale 1ns/1ps
interface i2cms_if;
  // Master pin drivers
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  // Slave pin drivers
  logic s_scl_o;
  logic s_scl_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  // Wired-and lines with pull-up
  logic scl;
  logic sda;

  assign scl = (m_scl_oe_n | m_scl_o) & (s_scl_oe_n | s_scl_o);
  assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

  modport master (
    input  scl,
    input  sda,
    output m_scl_o,
    output m_scl_oe_n,
    output m_sda_o,
    output m_sda_oe_n
  );
  modport slave (
    input  scl,
    input  sda,
    output s_scl_o,
    output s_scl_oe_n,
    output s_sda_o,
    output s_sda_oe_n
  );
endinterface

// file: design/i2cms_master.sv
`timescale 1ns/1ps
module i2cms_master
  import i2cms_pkg::*;
#(
  parameter int HALF = HALF_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Two-wire bus
  i2cms_if.master          bus,
  // Command port
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire i2cms_op_t   cmd_op,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_nack,
  // Byte result
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_nack
);
  localparam int TW = $clog2(HALF + 1);

  typedef struct packed {
    logic [1:0]    s1;
    logic [1:0]    s2;
    i2cms_mst_t    st;
    i2cms_op_t     op;
    logic [3:0]    bcnt;
    logic [8:0]    sh;
    logic [7:0]    rx;
    logic [TW-1:0] tm;
    logic          scl_oe_n;
    logic          sda_oe_n;
    logic          scl_o;
    logic          sda_o;
    logic          cmd_ready;
    logic          rsp_valid;
    logic [7:0]    rsp_data;
    logic          rsp_nack;
  } i2cms_ms_st_t;

  i2cms_ms_st_t r;
  i2cms_ms_st_t q;
  logic         scl_s;
  logic         sda_s;
  logic         take;
  logic         half_done;

  always_comb begin
    q = r;
    q.rsp_valid = 1'h0;
    q.s1 = {bus.sda, bus.scl};
    q.s2 = r.s1;
    scl_s = r.s2[LINE_SCL];
    sda_s = r.s2[LINE_SDA];
    take = cmd_valid & r.cmd_ready;
    half_done = (r.tm == TW'(HALF - 1));
    case (r.st)
      M_IDLE: begin
        // Only a start leaves idle; other commands are dropped
        if (take && cmd_op == OP_START) begin
          q.op = OP_START;
          q.tm = '0;
          q.st = M_START;
        end
      end
      M_START: begin
        // Wait for a free bus, pull SDA, then SCL
        if (r.sda_oe_n) begin
          if (scl_s && sda_s) begin
            q.sda_oe_n = 1'h0; // RL1
            q.tm = '0;
          end
        end else if (half_done) begin
          q.scl_oe_n = 1'h0;
          q.st = M_READY;
        end else begin
          q.tm = r.tm + 1'b1;
        end
      end
      M_READY: begin
        if (take) begin
          q.op = cmd_op;
          q.bcnt = 4'h0;
          q.tm = '0;
          q.st = M_LOW;
          case (cmd_op)
            OP_START: q.sh = SH_RELEASE;
            OP_STOP:  q.sh = SH_LOW; // RL21
            OP_WRITE: q.sh = {cmd_data, 1'h1}; // RL6 RL12
            default:  q.sh = {8'hff, cmd_nack}; // RL16
          endcase
        end
      end
      M_LOW: begin
        // Data bits move SDA only here, with SCL low; start and stop move it with SCL high
        if (r.tm == '0) begin
          q.sda_oe_n = r.sh[8]; // RL3 RL6
        end
        if (half_done) begin
          q.scl_oe_n = 1'h1;
          q.tm = '0;
          q.st = M_HIGH;
        end else begin
          q.tm = r.tm + 1'b1;
        end
      end
      M_HIGH: begin
        // Timing starts only once SCL is really high
        if (!scl_s) begin
          q.tm = '0; // RL5
        end else if (!half_done) begin
          q.tm = r.tm + 1'b1;
        end else begin
          q.tm = '0;
          case (r.op)
            OP_START: begin
              q.st = M_START;
            end
            OP_STOP: begin
              q.sda_oe_n = 1'h1; // RL2
              q.st = M_STOP;
            end
            default: begin
              q.sh = {r.sh[7:0], 1'h1};
              q.bcnt = r.bcnt + 1'b1;
              q.scl_oe_n = 1'h0; // RL4
              q.st = M_LOW;
              if (r.bcnt != BITS_BYTE) begin
                q.rx = {r.rx[6:0], sda_s};
              end else begin
                // Ninth pulse carries the acknowledge
                q.rsp_valid = 1'h1; // RL14 RL11
                q.rsp_data = r.rx;
                q.rsp_nack = sda_s;
                if (r.op == OP_WRITE && sda_s) begin
                  q.op = OP_STOP; // RL15
                  q.sh = SH_LOW;
                end else begin
                  q.st = M_READY;
                end
              end
            end
          endcase
        end
      end
      default: begin
        // Stop: bus free after SDA has risen
        if (half_done) begin
          q.st = M_IDLE;
        end else begin
          q.tm = r.tm + 1'b1;
        end
      end
    endcase
    q.cmd_ready = (q.st == M_IDLE) || (q.st == M_READY);
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.s1 <= '1;
      r.s2 <= '1;
      r.scl_oe_n <= 1'h1;
      r.sda_oe_n <= 1'h1;
      r.cmd_ready <= 1'h1;
    end else begin
      r <= q;
    end
  end

  // Outputs straight from the state register
  assign bus.m_scl_o = r.scl_o;
  assign bus.m_scl_oe_n = r.scl_oe_n;
  assign bus.m_sda_o = r.sda_o;
  assign bus.m_sda_oe_n = r.sda_oe_n;
  assign cmd_ready = r.cmd_ready;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data = r.rsp_data;
  assign rsp_nack = r.rsp_nack;
endmodule

// file: design/i2cms_pkg.sv
package i2cms_pkg;
  // Core clock rate
  localparam int CLK_MHZ = 40;
  // Spike suppression: a level must be seen this long to count
  localparam int GLITCH_NS = 50;
  localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int GC_W = $clog2(GLITCH_CYC + 1);
  // Half bit period at 400 kbps
  localparam int HALF_NS = 1250;
  localparam int HALF_CYC = (HALF_NS * CLK_MHZ + 999) / 1000;
  // Slave stretch after an address match, and data setup before SCL release
  localparam int ADDR_HOLD_NS = 100;
  localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int DSU_NS = 100;
  localparam int DSU_CYC = (DSU_NS * CLK_MHZ + 999) / 1000;
  localparam int HLD_MAX = (ADDR_HOLD_CYC > DSU_CYC) ? ADDR_HOLD_CYC : DSU_CYC;
  localparam int HLD_W = $clog2(HLD_MAX + 1);
  // Frame layout
  localparam int ADDR_W = 7;
  localparam int N_ALT = 4;
  localparam int BUF_DEPTH = 2;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [8:0] SH_RELEASE = 9'h1ff;
  localparam logic [8:0] SH_LOW = 9'h000;
  // Line index within the two-bit line vectors
  localparam int LINE_SCL = 0;
  localparam int LINE_SDA = 1;

  // Master command codes
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10,
    OP_STOP  = 2'b11
  } i2cms_op_t;

  // Slave protocol states
  typedef enum logic [3:0] {
    S_IDLE    = 4'b0000,
    S_ADDR    = 4'b0001,
    S_ADDR_AK = 4'b0010,
    S_HOLD    = 4'b0011,
    S_SETUP   = 4'b0100,
    S_RX      = 4'b0101,
    S_RX_AK   = 4'b0110,
    S_TX      = 4'b0111,
    S_TX_AK   = 4'b1000,
    S_IGNORE  = 4'b1001
  } i2cms_sst_t;

  // Master bit engine states
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_READY = 3'b001,
    M_LOW   = 3'b010,
    M_HIGH  = 3'b011,
    M_START = 3'b100,
    M_STOP  = 3'b101
  } i2cms_mst_t;

  // Slave status fields
  typedef struct packed {
    logic [2:0] idx;
    logic       nacked;
    logic       rstart;
    logic       rd;
    logic       hit;
    logic       busy;
  } i2cms_status_t;
endpackage

// file: design/i2cms_slave.sv
// Summary of operation
// RL1 - Start is SDA falling while SCL high
// RL2 - Stop is SDA rising while SCL high
// RL3 - SDA changes only while SCL low
// RL4 - Master gives one SCL pulse per bit
// RL5 - Slave may stretch SCL; master waits release
// RL6 - Address byte sent MSB first after start
// RL7 - Address LSB: zero write, one read
// RL8 - Answer only primary or four alternate addresses
// RL9 - Match: ACK, hold SCL low, set status
// RL10 - Unmatched address answered with NACK
// RL11 - Ninth pulse: SDA low ACK, high NACK
// RL12 - Transmitter releases SDA, receiver pulls low
// RL13 - Receiver ACK/NACK generated by hardware
// RL14 - Nine SCL pulses per byte from master
// RL15 - Master stops after receiving a NACK
// RL16 - Master NACKs last read; slave releases SDA
// RL17 - Stop returns slave to idle
// RL18 - Optional interrupt on stop detection
// RL19 - Setting forces slave to answer NACK
// RL20 - Byte flag on each byte moved
// RL21 - Start then stop ends any transfer
// RL22 - Reject spikes under 50 ns, 400 kbps
// RL23 - Repeated start with match raises event
`timescale 1ns/1ps
module i2cms_slave
  import i2cms_pkg::*;
#(
  parameter int NALT = N_ALT
) (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  // Two-wire bus
  i2cms_if.slave                            bus,
  // Own addresses and options
  input  wire logic [ADDR_W-1:0]            slave_primary_address_reg,
  input  wire logic [NALT-1:0][ADDR_W-1:0]  alt_addr,
  input  wire logic [NALT-1:0]              alt_en,
  input  wire logic                         force_nack,
  input  wire logic                         stop_irq_en,
  // Transmit byte for master reads
  input  wire logic [7:0]                   tx_data,
  input  wire logic                         tx_valid,
  output logic                              tx_ready,
  // Received bytes
  output logic [7:0]                        rx_data,
  output logic                              rx_valid,
  input  wire logic                         rx_ready,
  // Status and events
  output i2cms_status_t                     slave_status_reg,
  output logic                              byte_irq,
  output logic                              stop_irq,
  output logic                              rstart_irq
);
  typedef struct packed {
    logic [1:0]            s1;
    logic [1:0]            s2;
    logic [1:0]            flt;
    logic [1:0][GC_W-1:0]  gcnt;
    i2cms_sst_t            st;
    logic [3:0]            bcnt;
    logic [7:0]            sh;
    logic [HLD_W-1:0]      hold;
    logic                  in_xfer;
    logic                  scl_oe_n;
    logic                  sda_oe_n;
    logic                  scl_o;
    logic                  sda_o;
    i2cms_status_t         status;
    logic                  byte_irq;
    logic                  stop_irq;
    logic                  rstart_irq;
    logic                  tx_ready;
    logic                  push;
    logic [7:0]            push_data;
  } i2cms_sl_st_t;

  i2cms_sl_st_t r;
  i2cms_sl_st_t q;
  logic         buf_ready;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_c;
  logic         stop_c;
  logic         sda_now;
  logic         hit;
  logic [2:0]   idx;

  // Receive path decouples the bus from a slow reader
  i2cms_buf #(
    .W     (8),
    .DEPTH (BUF_DEPTH)
  ) u_rx_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (r.push),
    .in_data   (r.push_data),
    .in_ready  (buf_ready),
    .out_valid (rx_valid),
    .out_data  (rx_data),
    .out_ready (rx_ready)
  );

  always_comb begin
    q = r;
    q.push = 1'h0;
    q.byte_irq = 1'h0;
    q.stop_irq = 1'h0;
    q.rstart_irq = 1'h0;
    q.tx_ready = 1'h0;
    // Two-flop sync, then a run-length filter per line
    q.s1 = {bus.sda, bus.scl};
    q.s2 = r.s1;
    for (int i = 0; i < 2; i++) begin
      if (r.s2[i] == r.flt[i]) begin
        q.gcnt[i] = '0;
      end else if (r.gcnt[i] == GC_W'(GLITCH_CYC - 1)) begin
        q.flt[i] = r.s2[i]; // RL22
        q.gcnt[i] = '0;
      end else begin
        q.gcnt[i] = r.gcnt[i] + 1'b1;
      end
    end
    // Line events on the filtered levels
    scl_rise = q.flt[LINE_SCL] & ~r.flt[LINE_SCL];
    scl_fall = ~q.flt[LINE_SCL] & r.flt[LINE_SCL];
    start_c = r.flt[LINE_SDA] & ~q.flt[LINE_SDA] & r.flt[LINE_SCL] & q.flt[LINE_SCL]; // RL1
    stop_c = ~r.flt[LINE_SDA] & q.flt[LINE_SDA] & r.flt[LINE_SCL] & q.flt[LINE_SCL]; // RL2
    sda_now = q.flt[LINE_SDA];
    // Own address compare, primary first
    hit = (r.sh[7:1] == slave_primary_address_reg); // RL8
    idx = 3'h0;
    for (int k = 0; k < NALT; k++) begin
      if (!hit && alt_en[k] && (r.sh[7:1] == alt_addr[k])) begin
        hit = 1'h1; // RL8
        idx = 3'(k + 1);
      end
    end
    // Stop wins over start, both over bit traffic
    if (stop_c) begin
      q.st = S_IDLE; // RL17 RL21
      q.scl_oe_n = 1'h1;
      q.sda_oe_n = 1'h1;
      q.in_xfer = 1'h0;
      q.status.busy = 1'h0;
      q.stop_irq = stop_irq_en; // RL18
    end else if (start_c) begin
      q.st = S_ADDR;
      q.bcnt = 4'h0;
      q.scl_oe_n = 1'h1;
      q.sda_oe_n = 1'h1;
      q.status.rstart = r.in_xfer; // RL23
      q.status.hit = 1'h0;
      q.status.nacked = 1'h0;
      q.status.busy = 1'h1;
      q.in_xfer = 1'h1;
    end else begin
      case (r.st)
        S_ADDR: begin
          if (scl_rise) begin
            q.sh = {r.sh[6:0], sda_now}; // RL3
            q.bcnt = r.bcnt + 1'b1;
          end else if (scl_fall && r.bcnt == BITS_BYTE) begin
            if (hit) begin
              q.status.hit = 1'h1; // RL9
              q.status.rd = r.sh[0]; // RL7
              q.status.idx = idx;
              q.rstart_irq = r.status.rstart; // RL23
            end
            if (hit && !force_nack) begin
              q.sda_oe_n = 1'h0; // RL9 RL11 RL13
              q.st = S_ADDR_AK;
            end else begin
              q.status.nacked = 1'h1; // RL10 RL19
              q.st = S_IGNORE; // RL8
            end
          end
        end
        S_ADDR_AK: begin
          // End of ninth pulse: stretch before the first data bit
          if (scl_fall) begin
            q.sda_oe_n = 1'h1;
            q.scl_oe_n = 1'h0; // RL9 RL5
            q.hold = HLD_W'(ADDR_HOLD_CYC);
            q.bcnt = 4'h0;
            q.st = S_HOLD;
          end
        end
        S_HOLD: begin
          // SCL held low until the data side can go on
          if (r.hold != '0) begin
            q.hold = r.hold - 1'b1;
          end else if (r.status.rd) begin
            if (tx_valid) begin
              q.tx_ready = 1'h1;
              q.sh = tx_data;
              q.sda_oe_n = tx_data[7]; // RL3
              q.hold = HLD_W'(DSU_CYC);
              q.st = S_SETUP;
            end
          end else if (buf_ready) begin
            q.scl_oe_n = 1'h1; // RL5
            q.bcnt = 4'h0;
            q.st = S_RX;
          end
        end
        S_SETUP: begin
          // Data settles before SCL is let go
          if (r.hold != '0) begin
            q.hold = r.hold - 1'b1;
          end else begin
            q.scl_oe_n = 1'h1; // RL3 RL5
            q.bcnt = 4'h0;
            q.st = S_TX;
          end
        end
        S_RX: begin
          if (scl_rise) begin
            q.sh = {r.sh[6:0], sda_now};
            q.bcnt = r.bcnt + 1'b1;
          end else if (scl_fall && r.bcnt == BITS_BYTE) begin
            if (force_nack) begin
              q.status.nacked = 1'h1; // RL19 RL11
            end else begin
              q.sda_oe_n = 1'h0; // RL13 RL12
              q.push = 1'h1;
              q.push_data = r.sh;
              q.byte_irq = 1'h1; // RL20
            end
            q.st = S_RX_AK;
          end
        end
        S_RX_AK: begin
          if (scl_fall) begin
            q.sda_oe_n = 1'h1;
            q.bcnt = 4'h0;
            if (buf_ready) begin
              q.st = S_RX;
            end else begin
              q.scl_oe_n = 1'h0; // RL5
              q.hold = '0;
              q.st = S_HOLD;
            end
          end
        end
        S_TX: begin
          // Next bit goes out on the falling edge
          if (scl_fall) begin
            q.bcnt = r.bcnt + 1'b1;
            if (r.bcnt == BITS_BYTE - 4'h1) begin
              q.sda_oe_n = 1'h1; // RL12
              q.st = S_TX_AK;
            end else begin
              q.sh = {r.sh[6:0], 1'h1};
              q.sda_oe_n = r.sh[6]; // RL3
            end
          end
        end
        S_TX_AK: begin
          if (scl_rise) begin
            q.byte_irq = 1'h1; // RL20
            if (sda_now) begin
              q.status.nacked = 1'h1; // RL16 RL11
              q.st = S_IGNORE;
            end else begin
              q.st = S_ADDR_AK;
            end
          end
        end
        default: begin
          // Idle or not addressed: lines stay released
          q.scl_oe_n = 1'h1;
          q.sda_oe_n = 1'h1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.s1 <= '1;
      r.s2 <= '1;
      r.flt <= '1;
      r.scl_oe_n <= 1'h1;
      r.sda_oe_n <= 1'h1;
    end else begin
      r <= q;
    end
  end

  // Outputs straight from the state register
  assign bus.s_scl_o = r.scl_o;
  assign bus.s_scl_oe_n = r.scl_oe_n;
  assign bus.s_sda_o = r.sda_o;
  assign bus.s_sda_oe_n = r.sda_oe_n;
  assign tx_ready = r.tx_ready;
  assign slave_status_reg = r.status;
  assign byte_irq = r.byte_irq;
  assign stop_irq = r.stop_irq;
  assign rstart_irq = r.rstart_irq;
endmodule

// file: sim/i2c_master_slave_protocol_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module i2c_master_slave_protocol_tb;
  import i2cms_pkg::*;
  logic                          core_clk;
  logic                          rst_n;
  logic                          cmd_valid;
  logic                          cmd_ready;
  logic                          cmd_nack;
  logic                          rsp_valid;
  logic                          rsp_nack;
  i2cms_op_t                     cmd_op;
  logic [7:0]                    cmd_data;
  logic [7:0]                    rsp_data;
  logic [7:0]                    tx_data;
  logic [7:0]                    rx_data;
  logic [7:0]                    got_d;
  logic                          got_nk;
  logic [N_ALT-1:0][ADDR_W-1:0] alt_addr;
  logic [N_ALT-1:0]              alt_en;
  logic                          force_nack;
  logic                          stop_irq_en;
  logic                          tx_ready;
  logic                          rx_valid;
  logic                          rx_ready;
  logic                          byte_irq;
  logic                          stop_irq;
  logic                          rstart_irq;
  i2cms_status_t                 st;
  int                            errors;
  int                            check_count;
  int                            byte_n;
  int                            stop_n;
  int                            rs_n;
  int                            tx_idx;
  int                            n;
  logic [7:0]                    rxq[$];
  logic [7:0]                    tx_tab[4] = '{8'hc3, 8'h96, 8'h00, 8'h00};
  logic [6:0]                    adr_tab[5] = '{7'h2a, 7'h11, 7'h22, 7'h33, 7'h44};

  assign tx_data = tx_tab[tx_idx[1:0]];

  // Both ends joined over one bus
  i2cms_if u_i2cms_if ();
  i2cms_master #(.HALF(20)) u_i2cms_master (
    .core_clk(core_clk), .rst_n(rst_n), .bus(u_i2cms_if.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_nack(cmd_nack), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  i2cms_slave u_i2cms_slave (
    .core_clk(core_clk), .rst_n(rst_n), .bus(u_i2cms_if.slave),
    .slave_primary_address_reg(7'h2a), .alt_addr(alt_addr), .alt_en(alt_en),
    .force_nack(force_nack), .stop_irq_en(stop_irq_en), .tx_data(tx_data), .tx_valid(1'b1),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .slave_status_reg(st), .byte_irq(byte_irq), .stop_irq(stop_irq), .rstart_irq(rstart_irq));
  i2cms_properties u_i2cms_properties (
    .core_clk(core_clk), .rst_n(rst_n), .scl(u_i2cms_if.scl), .sda(u_i2cms_if.sda),
    .m_scl_oe_n(u_i2cms_if.m_scl_oe_n), .m_sda_oe_n(u_i2cms_if.m_sda_oe_n),
    .s_scl_oe_n(u_i2cms_if.s_scl_oe_n), .s_sda_oe_n(u_i2cms_if.s_sda_oe_n));

  // Clock, 25 ns period
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Event counters and receive drain; next transmit byte on each take
  always @(posedge core_clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
    byte_n += (byte_irq === 1'b1);
    stop_n += (stop_irq === 1'b1);
    rs_n   += (rstart_irq === 1'b1);
    if (tx_ready === 1'b1) #1 tx_idx = tx_idx + 1;
  end

  task automatic print_verdict();
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Bounded wait for the command port to be ready
  task automatic wait_ready();
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 9000);
    errors += (n >= 9000);
  endtask

  // Idle plus time for the slave filters to see the stop
  task automatic settle();
    wait_ready();
    repeat (20) @(posedge core_clk);
  endtask

  // One master command; byte commands return data and ack bit
  task automatic cmd(input i2cms_op_t op, input logic [7:0] d, input logic nk);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_data  = d;
    cmd_nack  = nk;
    wait_ready();
    #1 cmd_valid = 1'b0;
    if (op == OP_WRITE || op == OP_READ) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (rsp_valid !== 1'b1 && n < 9000);
      errors += (n >= 9000);
      got_d  = rsp_data;
      got_nk = rsp_nack;
    end
    if (op == OP_STOP) settle();
  endtask

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    alt_addr = {7'h44, 7'h33, 7'h22, 7'h11};
    alt_en = 4'hd;
    force_nack = 1'b0;
    stop_irq_en = 1'b1;
    rx_ready = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge core_clk);
    // Write burst to the primary address, receiver stalled when full
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_WRITE, {7'h2a, 1'b0}, 1'b0);
    `CHK(got_nk, 1'b0)
    `CHK({st.hit, st.rd, st.idx}, 5'h10)
    cmd(OP_WRITE, 8'ha5, 1'b0);
    cmd(OP_WRITE, 8'h3c, 1'b0);
    `CHK({rx_valid, rx_data}, 9'h1a5)
    fork
      begin
        repeat (300) @(posedge core_clk);
        #1 rx_ready = 1'b1;
      end
    join_none
    cmd(OP_WRITE, 8'h5a, 1'b0);
    `CHK(got_nk, 1'b0)
    cmd(OP_STOP, 8'h00, 1'b0);
    `CHK(st.busy, 1'b0)
    `CHK({rxq[0], rxq[1], rxq[2]}, 24'ha53c5a)
    `CHK(stop_n, 1)
    // Pointer write, repeated start, read two bytes, last one refused
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_WRITE, {7'h11, 1'b0}, 1'b0);
    cmd(OP_WRITE, 8'h07, 1'b0);
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_WRITE, {7'h11, 1'b1}, 1'b0);
    `CHK({st.rstart, st.rd, st.idx}, 5'h19)
    `CHK(rs_n, 1)
    cmd(OP_READ, 8'h00, 1'b0);
    `CHK(got_d, 8'hc3)
    cmd(OP_READ, 8'h00, 1'b1);
    `CHK({got_nk, got_d}, 9'h196)
    cmd(OP_STOP, 8'h00, 1'b0);
    `CHK(byte_n, 6)
    // Every own address, plus one whose enable is off
    for (int i = 0; i < 5; i++) begin
      cmd(OP_START, 8'h00, 1'b0);
      cmd(OP_WRITE, {adr_tab[i], 1'b0}, 1'b0);
      `CHK(got_nk, i == 2)
      if (i == 2) begin
        settle();
        `CHK({st.nacked, st.hit}, 2'h2)
        `CHK(st.busy, 1'b0)
      end else begin
        `CHK(st.idx, 3'(i))
        cmd(OP_STOP, 8'h00, 1'b0);
      end
    end
    // Forced refusal with the stop event masked
    #1 force_nack = 1'b1;
    stop_irq_en = 1'b0;
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_WRITE, {7'h2a, 1'b0}, 1'b0);
    `CHK(got_nk, 1'b1)
    settle();
    `CHK(stop_n, 7)
    #1 force_nack = 1'b0;
    stop_irq_en = 1'b1;
    // Abort by start then stop in mid-transfer
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_WRITE, {7'h33, 1'b0}, 1'b0);
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_STOP, 8'h00, 1'b0);
    `CHK({st.busy, 4'(stop_n)}, 5'h08)
    print_verdict();
  end
endmodule

// file: sim/i2cms_properties.sv
`timescale 1ns/1ps
module i2cms_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Line drivers of both ends
  input wire logic m_scl_oe_n,
  input wire logic m_sda_oe_n,
  input wire logic s_scl_oe_n,
  input wire logic s_sda_oe_n,
  // Wired lines
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       first;
  logic [3:0] cnt;
  wire        st_ev = scl & scl_q & sda_q & ~sda;
  wire        sp_ev = scl & scl_q & ~sda_q & sda;

  // Pulse position inside the first byte after a start
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first <= 1'b0;
      cnt   <= 4'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (st_ev) begin
        first <= 1'b1;
        cnt   <= 4'h0;
      end else if (sp_ev) begin
        first <= 1'b0;
      end else if (scl && !scl_q) begin
        cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
        if (cnt == 4'h9) first <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Line conditions only the master may make
  start_by_master_a: assert property (st_ev |-> !m_sda_oe_n && s_sda_oe_n)
    else $error("start not made by master");
  stop_by_master_a: assert property (sp_ev |-> m_sda_oe_n && s_sda_oe_n)
    else $error("stop not made by master");
  // Slave moves data or grabs the clock only while it is low; master keeps the high phase
  slave_sda_steady_a: assert property ($changed(s_sda_oe_n) |-> !scl)
    else $error("slave moved data with clock high");
  scl_high_min_a: assert property ($rose(scl) |-> m_scl_oe_n [*8])
    else $error("clock high phase cut short");
  stretch_low_a: assert property ($fell(s_scl_oe_n) |-> !scl)
    else $error("slave grabbed clock while high");
  // Address byte handling, and slave lines released after a stop
  addr_hold_a: assert property (first && cnt == 4'h9 && $fell(s_scl_oe_n) |-> !s_scl_oe_n [*4])
    else $error("address stretch too short");
  addr_release_a: assert property (first && cnt == 4'h9 && scl && scl_q |-> m_sda_oe_n)
    else $error("master held data in ack pulse");
  addr_quiet_a: assert property (first && scl && scl_q && cnt inside {[4'h1:4'h8]} |-> s_sda_oe_n)
    else $error("slave drove data during address");
  stop_release_a: assert property (sp_ev |-> (s_scl_oe_n && s_sda_oe_n) [*8])
    else $error("slave still driving after stop");

  // Main scenarios
  cover property (st_ev);
  cover property (first && cnt == 4'h9 && scl && !sda);
  cover property ($fell(s_scl_oe_n));
endmodule
